// file: hdl/mic_irq_arbiter.sv
// Fixed priority choice among enabled pending sources
`timescale 1ns/10ps
module mic_irq_arbiter (
  // Requests, bit index is the source code
  input wire logic [3:0] req,
  // Winner
  output logic valid,
  output mic_pkg::mic_src_t winner
);

  // Lowest index wins: external, timer 0, timer 1, timer 3
  always_comb begin
    valid = |req;
    winner = mic_pkg::SRC_TMR3;
    if (req[0]) begin
      winner = mic_pkg::SRC_EXT;
    end else if (req[1]) begin
      winner = mic_pkg::SRC_TMR0;
    end else if (req[2]) begin
      winner = mic_pkg::SRC_TMR1;
    end
  end

endmodule

// file: hdl/mic_irq_controller.sv
// Interrupt control logic: flags, enables, arbitration, vector call
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module mic_irq_controller #(
  parameter int STACK_DEPTH = mic_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [mic_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mic_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mic_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt sources
  input wire logic ext_irq_pin,
  input wire logic tmr0_overflow,
  input wire logic tmr1_overflow,
  input wire logic tmr3_overflow,
  // Core sequencer
  input wire logic phase_two_pulse,
  input wire logic call_instr,
  input wire logic plain_return_instr,
  input wire logic return_from_irq_instr,
  // Forced call to the core
  output logic irq_call,
  output logic [mic_pkg::VEC_W-1:0] irq_vector,
  // Stack view
  output logic [3:0] stack_level_pointer,
  output logic stack_full,
  // Event interrupt line
  output logic evt_irq
);

  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01
  } mic_state_t;

  mic_state_t state;
  mic_state_t next_state;

  logic global_irq_enable;
  logic ext_irq_enable;
  logic tmr0_irq_enable;
  logic tmr1_irq_enable;
  logic tmr3_irq_enable;
  logic ext_irq_flag;
  logic tmr0_irq_flag;
  logic tmr1_irq_flag;
  logic tmr3_irq_flag;

  logic ext_pin_q;
  logic ext_primed;
  logic ext_edge;
  logic phase_q;
  logic phase_rise;

  logic [3:0] pending;
  logic arb_valid;
  mic_pkg::mic_src_t arb_winner;
  logic take;
  logic stall_full;
  logic serve_ext;
  logic serve_tmr0;
  logic serve_tmr1;
  logic serve_tmr3;

  logic wr_primary;
  logic wr_secondary;
  logic wr_status;
  logic wr_mask;
  logic any_return;
  logic [3:0] level;
  logic full;

  logic [mic_pkg::EVT_W-1:0] evt_status;
  logic [mic_pkg::EVT_W-1:0] evt_mask;
  logic [mic_pkg::EVT_W-1:0] evt_set;
  logic [mic_pkg::DATA_W-1:0] next_rdata;

  // ==========================================================
  // Register decode
  assign wr_primary = reg_wr && reg_addr == mic_pkg::OFS_PRIMARY;
  assign wr_secondary = reg_wr && reg_addr == mic_pkg::OFS_SECONDARY;
  assign wr_status = reg_wr && reg_addr == mic_pkg::OFS_EVT_STATUS;
  assign wr_mask = reg_wr && reg_addr == mic_pkg::OFS_EVT_MASK;

  // ==========================================================
  // Source edge detection
  // First cycle after reset only primes, so a pin held high is not an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_pin_q <= 1'b0;
      ext_primed <= 1'b0;
    end else begin
      ext_pin_q <= ext_irq_pin;
      ext_primed <= 1'b1;
    end
  end

  assign ext_edge = ext_primed && (ext_irq_pin != ext_pin_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= phase_two_pulse;
    end
  end

  assign phase_rise = phase_two_pulse && !phase_q;

  // ==========================================================
  // Arbitration and acceptance
  always_comb begin
    pending = 4'h0;
    pending[mic_pkg::SRC_EXT] = ext_irq_flag && ext_irq_enable;
    pending[mic_pkg::SRC_TMR0] = tmr0_irq_flag && tmr0_irq_enable;
    pending[mic_pkg::SRC_TMR1] = tmr1_irq_flag && tmr1_irq_enable;
    pending[mic_pkg::SRC_TMR3] = tmr3_irq_flag && tmr3_irq_enable;
  end

  mic_irq_arbiter u_arbiter (
    .req(pending),
    .valid(arb_valid),
    .winner(arb_winner)
  );

  // Only at a phase-two rise, never while a call is in flight
  assign take = phase_rise && global_irq_enable && arb_valid
    && !full && state == ST_IDLE;
  assign stall_full = phase_rise && global_irq_enable && arb_valid
    && full;

  assign serve_ext = take && arb_winner == mic_pkg::SRC_EXT;
  assign serve_tmr0 = take && arb_winner == mic_pkg::SRC_TMR0;
  assign serve_tmr1 = take && arb_winner == mic_pkg::SRC_TMR1;
  assign serve_tmr3 = take && arb_winner == mic_pkg::SRC_TMR3;

  // ==========================================================
  // Enables
  // A return-from-interrupt beats a take in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      global_irq_enable <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_GLOBAL_EN];
    end else if (return_from_irq_instr) begin
      global_irq_enable <= 1'b1;
    end else if (take) begin
      global_irq_enable <= 1'b0;
    end else if (wr_primary) begin
      global_irq_enable <= reg_wdata[mic_pkg::PRI_GLOBAL_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_enable <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_EXT_EN];
      tmr0_irq_enable <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_TMR0_EN];
      tmr1_irq_enable <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_TMR1_EN];
    end else if (wr_primary) begin
      ext_irq_enable <= reg_wdata[mic_pkg::PRI_EXT_EN];
      tmr0_irq_enable <= reg_wdata[mic_pkg::PRI_TMR0_EN];
      tmr1_irq_enable <= reg_wdata[mic_pkg::PRI_TMR1_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr3_irq_enable <= mic_pkg::RST_SECONDARY[mic_pkg::SEC_TMR3_EN];
    end else if (wr_secondary) begin
      tmr3_irq_enable <= reg_wdata[mic_pkg::SEC_TMR3_EN];
    end
  end

  // ==========================================================
  // Request flags
  // Order per flag: write, then service clear, then a new event wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_flag <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_EXT_FLAG];
    end else if (ext_edge) begin
      ext_irq_flag <= 1'b1;
    end else if (serve_ext) begin
      ext_irq_flag <= 1'b0;
    end else if (wr_primary) begin
      ext_irq_flag <= reg_wdata[mic_pkg::PRI_EXT_FLAG];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr0_irq_flag <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_TMR0_FLAG];
    end else if (tmr0_overflow) begin
      tmr0_irq_flag <= 1'b1;
    end else if (serve_tmr0) begin
      tmr0_irq_flag <= 1'b0;
    end else if (wr_primary) begin
      tmr0_irq_flag <= reg_wdata[mic_pkg::PRI_TMR0_FLAG];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr1_irq_flag <= mic_pkg::RST_PRIMARY[mic_pkg::PRI_TMR1_FLAG];
    end else if (tmr1_overflow) begin
      tmr1_irq_flag <= 1'b1;
    end else if (serve_tmr1) begin
      tmr1_irq_flag <= 1'b0;
    end else if (wr_primary) begin
      tmr1_irq_flag <= reg_wdata[mic_pkg::PRI_TMR1_FLAG];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr3_irq_flag <= mic_pkg::RST_SECONDARY[mic_pkg::SEC_TMR3_FLAG];
    end else if (tmr3_overflow) begin
      tmr3_irq_flag <= 1'b1;
    end else if (serve_tmr3) begin
      tmr3_irq_flag <= 1'b0;
    end else if (wr_secondary) begin
      tmr3_irq_flag <= reg_wdata[mic_pkg::SEC_TMR3_FLAG];
    end
  end

  // ==========================================================
  // Call sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_CALL;
        end
      end
      ST_CALL: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Call pulse and vector; the core pushes its program counter only
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_call <= 1'b0;
    end else begin
      irq_call <= take;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_vector <= 8'h00;
    end else if (take) begin
      irq_vector <= mic_pkg::vector_of(arb_winner);
    end
  end

  // ==========================================================
  // Return stack level
  // Subroutine calls also fill the stack, so they count here too
  assign any_return = plain_return_instr || return_from_irq_instr;

  mic_stack_level #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(clk),
    .rst(rst),
    .push(take || call_instr),
    .pop(any_return),
    .level(level),
    .full(full)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_level_pointer <= 4'h0;
      stack_full <= 1'b0;
    end else begin
      stack_level_pointer <= level;
      stack_full <= full;
    end
  end

  // ==========================================================
  // Event status, mask and interrupt line
  always_comb begin
    evt_set = '0;
    evt_set[mic_pkg::EVT_TAKEN] = take;
    evt_set[mic_pkg::EVT_STALL_FULL] = stall_full;
    evt_set[mic_pkg::EVT_RETURN] = return_from_irq_instr;
  end

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_status <= mic_pkg::RST_EVT;
    end else if (wr_status) begin
      evt_status <= (evt_status & ~reg_wdata[mic_pkg::EVT_W-1:0])
        | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt_mask <= mic_pkg::RST_EVT;
    end else if (wr_mask) begin
      evt_mask <= reg_wdata[mic_pkg::EVT_W-1:0];
    end
  end

  // One cycle behind the status, so the line comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_irq <= 1'b0;
    end else begin
      evt_irq <= |(evt_status & evt_mask);
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      mic_pkg::OFS_PRIMARY: begin
        next_rdata[mic_pkg::PRI_GLOBAL_EN] = global_irq_enable;
        next_rdata[mic_pkg::PRI_EXT_EN] = ext_irq_enable;
        next_rdata[mic_pkg::PRI_TMR0_EN] = tmr0_irq_enable;
        next_rdata[mic_pkg::PRI_TMR1_EN] = tmr1_irq_enable;
        next_rdata[mic_pkg::PRI_EXT_FLAG] = ext_irq_flag;
        next_rdata[mic_pkg::PRI_TMR0_FLAG] = tmr0_irq_flag;
        next_rdata[mic_pkg::PRI_TMR1_FLAG] = tmr1_irq_flag;
      end
      mic_pkg::OFS_SECONDARY: begin
        next_rdata[mic_pkg::SEC_TMR3_EN] = tmr3_irq_enable;
        next_rdata[mic_pkg::SEC_TMR3_FLAG] = tmr3_irq_flag;
      end
      mic_pkg::OFS_EVT_STATUS: begin
        next_rdata[mic_pkg::EVT_W-1:0] = evt_status;
      end
      mic_pkg::OFS_EVT_MASK: begin
        next_rdata[mic_pkg::EVT_W-1:0] = evt_mask;
      end
      mic_pkg::OFS_STACK: begin
        next_rdata[3:0] = level;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// file: hdl/mic_pkg.sv
// Constants shared by the interrupt controller files
package mic_pkg;

  // ==========================================================
  // Bus and data widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int VEC_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_PRIMARY = 8'h0B;
  localparam logic [7:0] OFS_SECONDARY = 8'h1E;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h40;
  localparam logic [7:0] OFS_EVT_MASK = 8'h41;
  localparam logic [7:0] OFS_STACK = 8'h42;

  // ==========================================================
  // Field positions of irq_control_primary
  localparam int PRI_GLOBAL_EN = 0;
  localparam int PRI_EXT_EN = 1;
  localparam int PRI_TMR0_EN = 2;
  localparam int PRI_TMR1_EN = 3;
  localparam int PRI_EXT_FLAG = 4;
  localparam int PRI_TMR0_FLAG = 5;
  localparam int PRI_TMR1_FLAG = 6;

  // Field positions of irq_control_secondary
  localparam int SEC_TMR3_EN = 0;
  localparam int SEC_TMR3_FLAG = 1;

  // Event status bits
  localparam int EVT_W = 3;
  localparam int EVT_TAKEN = 0;
  localparam int EVT_STALL_FULL = 1;
  localparam int EVT_RETURN = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PRIMARY = 8'h00;
  localparam logic [7:0] RST_SECONDARY = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;

  // ==========================================================
  // Return stack and vectors
  localparam int STACK_DEPTH = 8;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_TMR0 = 8'h08;
  localparam logic [7:0] VEC_TMR1 = 8'h0C;
  localparam logic [7:0] VEC_TMR3 = 8'h14;

  // Sources, in falling priority
  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_TMR0 = 2'h1,
    SRC_TMR1 = 2'h2,
    SRC_TMR3 = 2'h3
  } mic_src_t;

  function automatic logic [7:0] vector_of(input mic_src_t src);
    case (src)
      SRC_EXT: vector_of = VEC_EXT;
      SRC_TMR0: vector_of = VEC_TMR0;
      SRC_TMR1: vector_of = VEC_TMR1;
      default: vector_of = VEC_TMR3;
    endcase
  endfunction

endpackage

// file: hdl/mic_stack_level.sv
// Return stack level tracker with full flag
`timescale 1ns/10ps
module mic_stack_level #(
  parameter int DEPTH = mic_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stack traffic
  input wire logic push,
  input wire logic pop,
  // Level
  output logic [3:0] level,
  output logic full
);

  logic [3:0] next_level;

  always_comb begin
    next_level = level;
    if (push && !pop && level != 4'(DEPTH)) begin
      next_level = level + 4'h1;
    end else if (pop && !push && level != 4'h0) begin
      next_level = level - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 4'h0;
    end else begin
      level <= next_level;
    end
  end

  // Full once every level is used
  always_ff @(posedge clk) begin
    if (rst) begin
      full <= 1'b0;
    end else begin
      full <= (next_level == 4'(DEPTH));
    end
  end

endmodule

// file: testbench/mic_core_model.sv
// Core sequencer model: phase-two pulses, calls and returns
`timescale 1ns/10ps
module mic_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench command: 1 plain return, 2 return from irq, 3 call
  input wire logic [1:0] cmd,
  // Sequencer outputs
  output logic phase_two_pulse,
  output logic call_instr,
  output logic plain_return_instr,
  output logic return_from_irq_instr
);
  // ====
  // Instruction cycle of four clocks
  logic [1:0] phase_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_cnt <= 2'h0;
      phase_two_pulse <= 1'b0;
    end else begin
      phase_cnt <= phase_cnt + 2'h1;
      phase_two_pulse <= (phase_cnt == 2'h3);
    end
  end
  // Instructions only when commanded, so nesting stays under bench control
  always_ff @(posedge clk) begin
    if (rst) begin
      call_instr <= 1'b0;
      plain_return_instr <= 1'b0;
      return_from_irq_instr <= 1'b0;
    end else begin
      call_instr <= (cmd == 2'h3);
      plain_return_instr <= (cmd == 2'h1);
      return_from_irq_instr <= (cmd == 2'h2);
    end
  end
endmodule

// file: testbench/mic_irq_controller_bench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module mic_irq_controller_bench;
  localparam logic [7:0] PRI = mic_pkg::OFS_PRIMARY;
  localparam logic [7:0] SEC = mic_pkg::OFS_SECONDARY;
  localparam logic [7:0] EST = mic_pkg::OFS_EVT_STATUS;
  localparam logic [7:0] EMK = mic_pkg::OFS_EVT_MASK;
  localparam logic [7:0] STK = mic_pkg::OFS_STACK;
  logic clk, rst, reg_wr, reg_rd, ext_irq_pin, irq_call, stack_full, evt_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_vector;
  logic [2:0] tmr_ovf;
  logic [3:0] stack_level_pointer;
  logic [1:0] cmd;
  logic phase_two_pulse, call_instr, plain_return_instr, return_from_irq_instr;
  logic [7:0] vecs [4] = '{8'h04, 8'h08, 8'h0C, 8'h14};
  int mismatches, samples_checked;

  mic_irq_controller dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_pin(ext_irq_pin), .tmr0_overflow(tmr_ovf[0]),
    .tmr1_overflow(tmr_ovf[1]), .tmr3_overflow(tmr_ovf[2]),
    .phase_two_pulse(phase_two_pulse), .call_instr(call_instr),
    .plain_return_instr(plain_return_instr),
    .return_from_irq_instr(return_from_irq_instr), .irq_call(irq_call),
    .irq_vector(irq_vector), .stack_level_pointer(stack_level_pointer),
    .stack_full(stack_full), .evt_irq(evt_irq));
  mic_core_model core (
    .clk(clk), .rst(rst), .cmd(cmd), .phase_two_pulse(phase_two_pulse),
    .call_instr(call_instr), .plain_return_instr(plain_return_instr),
    .return_from_irq_instr(return_from_irq_instr));

  // ====
  // Bus, compare and closing tasks
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check_byte(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_expect(input string n, input logic [7:0] a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check_byte(n, e, reg_rdata);
  endtask
  task automatic core_cmd(input logic [1:0] v);
    @(posedge clk);
    cmd <= v;
    @(posedge clk);
    cmd <= 2'h0;
  endtask
  // Source 0 is the pin, toggled; timers pulse for one cycle
  task automatic pulse(input int i);
    @(posedge clk);
    if (i == 0) begin
      ext_irq_pin <= ~ext_irq_pin;
    end else begin
      tmr_ovf[i-1] <= 1'b1;
    end
    @(posedge clk);
    tmr_ovf <= 3'h0;
  endtask
  task automatic wait_call(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq_call !== 1'b1 && n < 40);
    if (irq_call !== 1'b1) begin
      mismatches++;
      $display("FAIL irq_call expected 1 seen 0");
      conclude();
    end else begin
      check_byte("irq_vector", e, irq_vector);
    end
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      check_bit("irq_call", 1'b0, irq_call);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ====
  // Scenarios
  task automatic t_registers();
    reg_expect("primary", PRI, 8'h00);
    reg_expect("secondary", SEC, 8'h00);
    reg_expect("evt_status", EST, 8'h00);
    reg_expect("stack", STK, 8'h00);
    reg_write(8'h55, 8'hFF);
    reg_expect("unmapped", 8'h55, 8'h00);
    reg_write(PRI, 8'hFE);
    reg_expect("primary", PRI, 8'h7E);
    reg_write(SEC, 8'hFF);
    reg_expect("secondary", SEC, 8'h03);
    reg_write(PRI, 8'h00);
    reg_write(SEC, 8'h00);
    reg_expect("primary", PRI, 8'h00);
  endtask
  task automatic t_each_source();
    reg_write(PRI, 8'h0F);
    reg_write(SEC, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      wait_call(vecs[i]);
      reg_expect("primary", PRI, 8'h0E);
      reg_expect("secondary", SEC, 8'h01);
      core_cmd(2'h2);
      reg_expect("primary", PRI, 8'h0F);
    end
  endtask
  task automatic t_plain_return();
    pulse(0);
    wait_call(8'h04);
    reg_expect("stack", STK, 8'h01);
    core_cmd(2'h1);
    reg_expect("primary", PRI, 8'h0E);
    reg_expect("stack", STK, 8'h00);
  endtask
  task automatic t_mask_priority();
    @(posedge clk);
    ext_irq_pin <= ~ext_irq_pin;
    tmr_ovf <= 3'h7;
    @(posedge clk);
    tmr_ovf <= 3'h0;
    no_call(12);
    reg_expect("primary", PRI, 8'h7E);
    reg_expect("secondary", SEC, 8'h03);
    reg_write(PRI, 8'h7F);
    for (int i = 0; i < 4; i++) begin
      wait_call(vecs[i]);
      core_cmd(2'h2);
    end
  endtask
  task automatic t_event_line();
    reg_write(EST, 8'h07);
    reg_write(EMK, 8'h01);
    pulse(2);
    wait_call(8'h0C);
    idle(2);
    check_bit("evt_irq", 1'b1, evt_irq);
    reg_write(EMK, 8'h00);
    idle(2);
    check_bit("evt_irq", 1'b0, evt_irq);
    reg_write(EMK, 8'h01);
    idle(2);
    check_bit("evt_irq", 1'b1, evt_irq);
    reg_write(EST, 8'h01);
    idle(2);
    check_bit("evt_irq", 1'b0, evt_irq);
    core_cmd(2'h2);
    reg_expect("evt_status", EST, 8'h04);
  endtask
  task automatic t_stack_full();
    reg_write(PRI, 8'h00);
    repeat (8) core_cmd(2'h3);
    reg_expect("stack", STK, 8'h08);
    check_byte("stack_level_pointer", 8'h08, {4'h0, stack_level_pointer});
    check_bit("stack_full", 1'b1, stack_full);
    reg_write(EST, 8'h07);
    reg_write(PRI, 8'h05);
    pulse(1);
    no_call(12);
    reg_expect("evt_status", EST, 8'h02);
    reg_expect("primary", PRI, 8'h25);
    core_cmd(2'h1);
    wait_call(8'h08);
    reg_expect("stack", STK, 8'h08);
    repeat (8) core_cmd(2'h1);
  endtask

  // ====
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ext_irq_pin = 1'b0;
    tmr_ovf = 3'h0;
    cmd = 2'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_registers();
    t_each_source();
    t_plain_return();
    t_mask_priority();
    t_event_line();
    t_stack_full();
    conclude();
  end
endmodule

// file: testbench/mic_irq_controller_properties.sv
// Port-level checker for the interrupt controller
`timescale 1ns/10ps
module mic_irq_controller_properties #(
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic phase_two_pulse,
  input wire logic call_instr,
  input wire logic plain_return_instr,
  input wire logic return_from_irq_instr,
  input wire logic irq_call,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] stack_level_pointer,
  input wire logic stack_full
);
  // ====
  // Steps of stack traffic
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_push;
    irq_call && !$past(call_instr) && !$past(plain_return_instr)
      && !$past(return_from_irq_instr);
  endsequence
  sequence s_pop;
    (plain_return_instr || return_from_irq_instr) && !call_instr
      ##1 !irq_call && stack_level_pointer != 4'h0;
  endsequence
  // ====
  // Assertions
  AST_CALL_ON_RISE:
    assert property (irq_call |-> $past(phase_two_pulse)
      && !$past(phase_two_pulse, 2)) else $error("call off a phase rise");
  AST_QUIET_AFTER_CALL:
    assert property (irq_call |=> !irq_call [*3])
      else $error("call repeated inside one instruction");
  AST_VECTOR_SET:
    assert property (irq_call |-> irq_vector inside
      {8'h04, 8'h08, 8'h0C, 8'h14}) else $error("illegal vector");
  AST_FULL_NO_TAKE:
    assert property (irq_call |-> !stack_full)
      else $error("call taken on full stack");
  AST_FULL_MATCH:
    assert property (stack_full == (stack_level_pointer == 4'(STACK_DEPTH)))
      else $error("full flag disagrees with level");
  AST_LEVEL_PUSH:
    assert property (s_push |=> stack_level_pointer ==
      $past(stack_level_pointer) + 4'h1) else $error("take did not push");
  AST_LEVEL_POP:
    assert property (s_pop |=> stack_level_pointer ==
      $past(stack_level_pointer) - 4'h1) else $error("return did not pop");
  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule

bind mic_irq_controller mic_irq_controller_properties #(
  .STACK_DEPTH(STACK_DEPTH)
) chk (
  .clk(clk),
  .rst(rst),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .phase_two_pulse(phase_two_pulse),
  .call_instr(call_instr),
  .plain_return_instr(plain_return_instr),
  .return_from_irq_instr(return_from_irq_instr),
  .irq_call(irq_call),
  .irq_vector(irq_vector),
  .stack_level_pointer(stack_level_pointer),
  .stack_full(stack_full)
);
